/* design/dcmon_pkg.sv */
// Constants of the drive condition monitor: map, fields, resets, codes.
// Assumes a 125 MHz system clock and a 32-bit AXI4-Lite register bus.

package dcmon_pkg;

  // Register byte offsets.
  localparam logic [7:0] ADDR_STALL  = 8'h00;
  localparam logic [7:0] ADDR_FDET   = 8'h04;
  localparam logic [7:0] ADDR_FUNC   = 8'h08;
  localparam logic [7:0] ADDR_OVT    = 8'h0C;
  localparam logic [7:0] ADDR_TIMER  = 8'h10;
  localparam logic [7:0] ADDR_PROT   = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_CLEAR  = 8'h1C;

  // Field positions (low bit of each field).
  localparam int POS_ACCEL_LVL = 0;
  localparam int POS_RUN_LVL   = 8;
  localparam int POS_OUT1_FN   = 0;
  localparam int POS_OUT2_FN   = 8;
  localparam int POS_IN_FN     = 16;
  localparam int POS_OT_MODE   = 0;
  localparam int POS_OT_LVL    = 8;
  localparam int POS_OT_TIME   = 16;
  localparam int POS_TON       = 0;
  localparam int POS_TOFF      = 8;

  // Reset values.
  localparam logic [7:0]  RST_ACCEL_LVL = 8'hAA;  // 170 percent
  localparam logic [7:0]  RST_RUN_LVL   = 8'hA0;  // 160 percent
  localparam logic [11:0] RST_FDET      = 12'h000;
  localparam logic [4:0]  RST_FN        = 5'h00;
  localparam logic [2:0]  RST_OT_MODE   = 3'h0;
  localparam logic [7:0]  RST_OT_LVL    = 8'hA0;  // 160 percent
  localparam logic [7:0]  RST_OT_TIME   = 8'h01;  // 0.1 s
  localparam logic [7:0]  RST_TDELAY    = 8'h00;

  // Setting limits.
  localparam logic [7:0]  PCT_MIN     = 8'h1E;    // 30 percent
  localparam logic [7:0]  PCT_MAX     = 8'hC8;    // 200 percent
  localparam logic [11:0] FDET_MAX    = 12'hFA0;  // 400.0 Hz
  localparam logic [7:0]  OT_TIME_MIN = 8'h01;    // 0.1 s
  localparam logic [7:0]  OT_TIME_MAX = 8'h64;    // 10.0 s
  localparam logic [2:0]  OT_MODE_MAX = 3'h4;

  // Contact output and input function codes.
  localparam logic [4:0] FN_FREQ_EQ  = 5'h03;
  localparam logic [4:0] FN_FREQ_LE  = 5'h04;
  localparam logic [4:0] FN_FREQ_GE  = 5'h05;
  localparam logic [4:0] FN_OVT      = 5'h06;
  localparam logic [4:0] FN_TIMER    = 5'h0B;
  localparam logic [4:0] IN_FN_TIMER = 5'h14;

  // Overtorque modes.
  localparam logic [2:0] OT_OFF        = 3'h0;
  localparam logic [2:0] OT_AGREE_WARN = 3'h1;
  localparam logic [2:0] OT_RUN_WARN   = 3'h2;
  localparam logic [2:0] OT_AGREE_TRIP = 3'h3;
  localparam logic [2:0] OT_RUN_TRIP   = 3'h4;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Timing: all delays count in tenths of a second.
  localparam int CLK_HZ      = 125_000_000;
  localparam int TICK_MS     = 100;
  localparam int TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;

endpackage

/* design/dcmon_top.sv */
// Drive condition monitor: stall prevention request, frequency detection,
// overtorque detection, contact delay timer and resistor overheat trip.
// Assumes current and frequency arrive on the system clock; the timer
// input and the overheat contact arrive asynchronously from pins.
//
// Overview of operation
// [RQ1] Request frequency reduction when current reaches accel or run level.
// [RQ2] Stall levels settable 30 to 200 percent in 1 percent steps.
// [RQ3] Hold frequency detect level 0.0 to 400.0 Hz and compare always.
// [RQ4] Output function 3 asserts while frequency equals detect level.
// [RQ5] Output function 4 asserts while frequency is at or below level.
// [RQ6] Output function 5 asserts while frequency is at or above level.
// [RQ7] Overtorque only after current held at or above level for set time.
// [RQ8] Overtorque level 30 to 200 percent, default 160.
// [RQ9] Overtorque time 0.1 to 10.0 seconds, default 0.1.
// [RQ10] Mode 0 never declares overtorque.
// [RQ11] Mode 1 checks during speed agreement, warns and keeps running.
// [RQ12] Mode 2 checks while running, warns and keeps running.
// [RQ13] Mode 3 checks during speed agreement and trips output off.
// [RQ14] Mode 4 checks while running and trips output off.
// [RQ15] A contact output can show overtorque detected.
// [RQ16] Timer works only with input code 20 and output code 11.
// [RQ17] Timer output turns on after input on for the on delay.
// [RQ18] Timer output turns off after input off for the off delay.
// [RQ19] Overheat enable 1 shows an error and shuts output off.
// [RQ20] Overheat enable 0 ignores the resistor overheat input.
// [RQ21] Input change before delay expiry restarts timing, output unchanged.
//
// Implementation choices: the register addresses and the AXI4-Lite slave port.

`timescale 1ns/100ps
`default_nettype none

module dcmon_top
  import dcmon_pkg::*;
#(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Measurement path, same clock domain.
  input  wire logic [8:0]  out_current_pct,
  input  wire logic [11:0] out_freq,
  input  wire logic        drive_running,
  input  wire logic        drive_accel,
  input  wire logic        speed_agree,
  // Asynchronous contact inputs.
  input  wire logic        timer_in_pin,
  input  wire logic        resistor_overheat_input,
  // Results toward output stage and contacts.
  output logic             stall_reduce,
  output logic             contact_out1,
  output logic             contact_out2,
  output logic             overtorque_warn,
  output logic             output_shutoff,
  output logic             fault_overtorque,
  output logic             fault_overheat
);
  localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES_P - 1);
  typedef struct packed {
    logic        awready, wready, aw_got, w_got;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready, rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [7:0]  accel_stall_level, run_stall_level;
    logic [11:0] freq_detect_level;
    logic [4:0]  contact_out1_function, contact_out2_function;
    logic [4:0]  input_function;
    logic [2:0]  overtorque_mode_select;
    logic [7:0]  overtorque_level, overtorque_time;
    logic [7:0]  timer_on_delay, timer_off_delay;
    logic        resistor_overheat_enable;
    logic        tin_s1, tin_s2, rh_s1, rh_s2;
    logic [23:0] ot_pre;
    logic [7:0]  ot_cnt;
    logic        ot_det, ot_warn, ot_fault;
    logic [23:0] tm_pre;
    logic [7:0]  tm_cnt;
    logic        tm_out, rh_fault, shut;
    logic        stall, freq_eq, freq_le, freq_ge, c1, c2;
  } dcmon_state_type;

  dcmon_state_type st_r;
  dcmon_state_type st_nxt;

  ////////////////////////////////////////////////////////////////////////
  // Helper functions.
  // Holds a percentage setting inside the legal window.
  function automatic logic [7:0] clamp_pct(input logic [7:0] v);
    return (v < PCT_MIN) ? PCT_MIN : (v > PCT_MAX) ? PCT_MAX : v;
  endfunction

  // Merges the enabled byte lanes of a write into an old register image.
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  // Value of one contact output for its selected function.
  function automatic logic contact_val(input logic [4:0] fn,
                                       input dcmon_state_type s);
    logic r;
    r = 1'b0;
    case (fn)
      FN_FREQ_EQ: r = s.freq_eq;           // RQ4
      FN_FREQ_LE: r = s.freq_le;           // RQ5
      FN_FREQ_GE: r = s.freq_ge;           // RQ6
      FN_OVT:     r = s.ot_det;            // RQ15
      FN_TIMER:   r = s.tm_out;            // RQ16
      default:    r = 1'b0;
    endcase
    return r;
  endfunction

  // Register read image for one address; unmapped reads as zero.
  function automatic logic [31:0] reg_image(input logic [7:0] a,
                                            input dcmon_state_type s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      ADDR_STALL: begin
        r[POS_ACCEL_LVL +: 8] = s.accel_stall_level;
        r[POS_RUN_LVL +: 8]   = s.run_stall_level;
      end
      ADDR_FDET:  r[11:0] = s.freq_detect_level;
      ADDR_FUNC: begin
        r[POS_OUT1_FN +: 5] = s.contact_out1_function;
        r[POS_OUT2_FN +: 5] = s.contact_out2_function;
        r[POS_IN_FN +: 5]   = s.input_function;
      end
      ADDR_OVT: begin
        r[POS_OT_MODE +: 3] = s.overtorque_mode_select;
        r[POS_OT_LVL +: 8]  = s.overtorque_level;
        r[POS_OT_TIME +: 8] = s.overtorque_time;
      end
      ADDR_TIMER: begin
        r[POS_TON +: 8]  = s.timer_on_delay;
        r[POS_TOFF +: 8] = s.timer_off_delay;
      end
      ADDR_PROT:  r[0] = s.resistor_overheat_enable;
      ADDR_STATUS:
        r[10:0] = {s.tin_s2, s.rh_s2, s.tm_out, s.rh_fault, s.ot_fault,
                   s.ot_warn, s.ot_det, s.freq_ge, s.freq_le, s.freq_eq,
                   s.stall};
      default:    r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // True for addresses that exist on the bus.
  function automatic logic mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_CLEAR);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  // All next values come from registered state and inputs alone.
  always_comb begin
    logic [31:0] img, wv;
    logic [8:0]  stall_lvl;
    logic [7:0]  tm_dly;
    logic        ot_qual, ot_cond, tm_en, clr_ot, clr_rh;
    img       = 32'h0000_0000;
    wv        = 32'h0000_0000;
    stall_lvl = 9'h000;
    ot_qual   = 1'b0;
    ot_cond   = 1'b0;
    tm_en     = 1'b0;
    tm_dly    = 8'h00;
    clr_ot    = 1'b0;
    clr_rh    = 1'b0;
    st_nxt    = st_r;
    // Two-stage synchronisers for the asynchronous pins.
    st_nxt.tin_s1 = timer_in_pin;
    st_nxt.tin_s2 = st_r.tin_s1;
    st_nxt.rh_s1  = resistor_overheat_input;
    st_nxt.rh_s2  = st_r.rh_s1;
    // Write channel: address and data taken in either order.
    if (st_r.awready && s_axi_awvalid) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.awaddr = s_axi_awaddr;
    end
    if (st_r.wready && s_axi_wvalid) begin
      st_nxt.w_got = 1'b1;
      st_nxt.wdata = s_axi_wdata;
      st_nxt.wstrb = s_axi_wstrb;
    end
    if (st_r.bvalid && s_axi_bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got  = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp  = mapped(st_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      img = reg_image(st_r.awaddr, st_r);
      wv  = merge(img, st_r.wdata, st_r.wstrb);
      // Out-of-range settings are clamped so the logic never sees them.
      case (st_r.awaddr)
        ADDR_STALL: begin
          st_nxt.accel_stall_level =
            clamp_pct(wv[POS_ACCEL_LVL +: 8]);               // RQ2
          st_nxt.run_stall_level = clamp_pct(wv[POS_RUN_LVL +: 8]); // RQ2
        end
        ADDR_FDET: begin
          st_nxt.freq_detect_level =
            (wv[11:0] > FDET_MAX) ? FDET_MAX : wv[11:0];     // RQ3
        end
        ADDR_FUNC: begin
          st_nxt.contact_out1_function = wv[POS_OUT1_FN +: 5];
          st_nxt.contact_out2_function = wv[POS_OUT2_FN +: 5];
          st_nxt.input_function        = wv[POS_IN_FN +: 5];
        end
        ADDR_OVT: begin
          st_nxt.overtorque_mode_select =
            (wv[POS_OT_MODE +: 3] > OT_MODE_MAX) ? OT_MODE_MAX
                                                 : wv[POS_OT_MODE +: 3];
          st_nxt.overtorque_level = clamp_pct(wv[POS_OT_LVL +: 8]); // RQ8
          st_nxt.overtorque_time =
            (wv[POS_OT_TIME +: 8] < OT_TIME_MIN) ? OT_TIME_MIN :
            (wv[POS_OT_TIME +: 8] > OT_TIME_MAX) ? OT_TIME_MAX :
            wv[POS_OT_TIME +: 8];                               // RQ9
        end
        ADDR_TIMER: begin
          st_nxt.timer_on_delay  = wv[POS_TON +: 8];
          st_nxt.timer_off_delay = wv[POS_TOFF +: 8];
        end
        ADDR_PROT:  st_nxt.resistor_overheat_enable = wv[0];
        ADDR_CLEAR: begin
          clr_ot = st_r.wstrb[0] & st_r.wdata[0];
          clr_rh = st_r.wstrb[0] & st_r.wdata[1];
        end
        default: ;
      endcase
    end
    // One write in flight: both channels close until the response goes.
    st_nxt.awready = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wready  = !st_nxt.w_got && !st_nxt.bvalid;
    // Read channel: one cycle from address to data.
    if (st_r.rvalid && s_axi_rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (st_r.arready && s_axi_arvalid) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata  = reg_image(s_axi_araddr, st_r);
      st_nxt.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    st_nxt.arready = !st_nxt.rvalid;
    // Stall prevention asks for a lower frequency at the active level.
    stall_lvl = {1'b0, drive_accel ? st_r.accel_stall_level
                                   : st_r.run_stall_level};
    st_nxt.stall = drive_running && (out_current_pct >= stall_lvl); // RQ1
    // Frequency detection runs whatever the output functions are.
    st_nxt.freq_eq = (out_freq == st_r.freq_detect_level);        // RQ3
    st_nxt.freq_le = (out_freq <= st_r.freq_detect_level);        // RQ3
    st_nxt.freq_ge = (out_freq >= st_r.freq_detect_level);        // RQ3
    // Overtorque qualification depends on the selected mode.
    case (st_r.overtorque_mode_select)
      OT_AGREE_WARN, OT_AGREE_TRIP:
        ot_qual = drive_running && speed_agree;               // RQ11 RQ13
      OT_RUN_WARN, OT_RUN_TRIP:
        ot_qual = drive_running;                              // RQ12 RQ14
      default:
        ot_qual = 1'b0;                                       // RQ10
    endcase
    ot_cond = ot_qual &&
              (out_current_pct >= {1'b0, st_r.overtorque_level});
    // Any dip below the level restarts the timing from zero.
    if (!ot_cond) begin
      st_nxt.ot_pre = 24'h000000;                             // RQ7
      st_nxt.ot_cnt = 8'h00;
      st_nxt.ot_det = 1'b0;
    end else if (st_r.ot_cnt >= st_r.overtorque_time) begin
      st_nxt.ot_det = 1'b1;                                   // RQ7
    end else if (st_r.ot_pre == TICK_LAST) begin
      st_nxt.ot_pre = 24'h000000;
      st_nxt.ot_cnt = st_r.ot_cnt + 8'h01;
    end else begin
      st_nxt.ot_pre = st_r.ot_pre + 24'h000001;
    end
    st_nxt.ot_warn = st_nxt.ot_det &&
      ((st_r.overtorque_mode_select == OT_AGREE_WARN) ||
       (st_r.overtorque_mode_select == OT_RUN_WARN));        // RQ11 RQ12
    // A trip latches; a new detection wins over a software clear.
    if (st_nxt.ot_det &&
        ((st_r.overtorque_mode_select == OT_AGREE_TRIP) ||
         (st_r.overtorque_mode_select == OT_RUN_TRIP))) begin
      st_nxt.ot_fault = 1'b1;                                 // RQ13 RQ14
    end else if (clr_ot) begin
      st_nxt.ot_fault = 1'b0;
    end
    // Overheat trip also latches while the contact stays asserted.
    if (st_r.resistor_overheat_enable && st_r.rh_s2) begin
      st_nxt.rh_fault = 1'b1;                                 // RQ19
    end else if (clr_rh) begin
      st_nxt.rh_fault = 1'b0;                                 // RQ20
    end
    // Shut-off gets its own flop so the pin has no gate behind it.
    st_nxt.shut = st_nxt.ot_fault | st_nxt.rh_fault;         // RQ13 RQ19
    // Delay timer runs only when both ends are assigned to it.
    tm_en = (st_r.input_function == IN_FN_TIMER) &&
            ((st_r.contact_out1_function == FN_TIMER) ||
             (st_r.contact_out2_function == FN_TIMER));       // RQ16
    tm_dly = st_r.tin_s2 ? st_r.timer_on_delay : st_r.timer_off_delay;
    if (!tm_en) begin
      st_nxt.tm_out = 1'b0;                                   // RQ16
      st_nxt.tm_pre = 24'h000000;
      st_nxt.tm_cnt = 8'h00;
    end else if (st_r.tin_s2 == st_r.tm_out) begin
      // Input back at the output level: drop any partial delay.
      st_nxt.tm_pre = 24'h000000;                             // RQ21
      st_nxt.tm_cnt = 8'h00;
    end else if (st_r.tm_cnt >= tm_dly) begin
      st_nxt.tm_out = st_r.tin_s2;                            // RQ17 RQ18
      st_nxt.tm_pre = 24'h000000;
      st_nxt.tm_cnt = 8'h00;
    end else if (st_r.tm_pre == TICK_LAST) begin
      st_nxt.tm_pre = 24'h000000;
      st_nxt.tm_cnt = st_r.tm_cnt + 8'h01;
    end else begin
      st_nxt.tm_pre = st_r.tm_pre + 24'h000001;
    end
    // Contact outputs follow their selected function.
    st_nxt.c1 = contact_val(st_r.contact_out1_function, st_r);
    st_nxt.c2 = contact_val(st_r.contact_out2_function, st_r);
  end

  ////////////////////////////////////////////////////////////////////////
  // State register.
  // Synchronous reset loads constants only.
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_r                          <= '0;
      st_r.accel_stall_level        <= RST_ACCEL_LVL;
      st_r.run_stall_level          <= RST_RUN_LVL;
      st_r.freq_detect_level        <= RST_FDET;
      st_r.contact_out1_function    <= RST_FN;
      st_r.contact_out2_function    <= RST_FN;
      st_r.input_function           <= RST_FN;
      st_r.overtorque_mode_select   <= RST_OT_MODE;
      st_r.overtorque_level         <= RST_OT_LVL;
      st_r.overtorque_time          <= RST_OT_TIME;
      st_r.timer_on_delay           <= RST_TDELAY;
      st_r.timer_off_delay          <= RST_TDELAY;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, each straight from a flip-flop.
  assign s_axi_awready    = st_r.awready;
  assign s_axi_wready     = st_r.wready;
  assign s_axi_bresp      = st_r.bresp;
  assign s_axi_bvalid     = st_r.bvalid;
  assign s_axi_arready    = st_r.arready;
  assign s_axi_rdata      = st_r.rdata;
  assign s_axi_rresp      = st_r.rresp;
  assign s_axi_rvalid     = st_r.rvalid;
  assign stall_reduce     = st_r.stall;
  assign contact_out1     = st_r.c1;
  assign contact_out2     = st_r.c2;
  assign overtorque_warn  = st_r.ot_warn;
  assign output_shutoff   = st_r.shut;
  assign fault_overtorque = st_r.ot_fault;
  assign fault_overheat   = st_r.rh_fault;

endmodule // dcmon_top

`default_nettype wire

/* tb/dcmon_partner.sv */
// Model of the output stage and measurement path.
// Assumes the bench sets load current, reference and run command.
`timescale 1ns/100ps
`default_nettype none
module dcmon_partner (
  // Clock, reset and bench settings.
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [8:0]  cur_set,
  input  wire logic [11:0] freq_set,
  input  wire logic        run_cmd,
  input  wire logic        agree_cmd,
  // Requests from the monitor.
  input  wire logic        stall_reduce,
  input  wire logic        output_shutoff,
  // Measurements back to the monitor.
  output logic [8:0]       out_current_pct,
  output logic [11:0]      out_freq,
  output logic             drive_running,
  output logic             drive_accel,
  output logic             speed_agree
);
  // A shut-off stage stops the motor; a stall request trims speed.
  always_ff @(posedge clk_sys) begin
    out_current_pct <= rst_n ? cur_set : 9'h000;
    out_freq <= (rst_n && stall_reduce) ? out_freq - 12'h001 : freq_set;
    drive_running <= rst_n && run_cmd && !output_shutoff;
    drive_accel <= rst_n && run_cmd && !agree_cmd;
    speed_agree <= drive_running && agree_cmd;
  end
endmodule // dcmon_partner
`default_nettype wire

/* tb/dcmon_checker.sv */
// Checks monitor ports: bus answers, overtorque timing, trips.
// Assumes a bind into dcmon_top that hands on the tick.
`timescale 1ns/100ps
`default_nettype none
module dcmon_checker
  import dcmon_pkg::*;
#(parameter int TICK_CYCLES_P = 10) (
  // Clock and reset.
  input wire logic       clk_sys,
  input wire logic       rst_n,
  // Bus handshakes.
  input wire logic       s_axi_awvalid,
  input wire logic       s_axi_awready,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_wready,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_bready,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid,
  // Monitor inputs and results.
  input wire logic [8:0] out_current_pct,
  input wire logic       overtorque_warn,
  input wire logic       output_shutoff,
  input wire logic       fault_overtorque,
  input wire logic       fault_overheat
);
  logic [31:0] hi_cnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Run length of current at or above the lowest settable level.
  always_ff @(posedge clk_sys) begin
    if (!rst_n || out_current_pct < 9'(PCT_MIN)) hi_cnt_r <= 32'h0;
    else hi_cnt_r <= hi_cnt_r + 32'h1;
  end
  a_b_latency: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("late bvalid");
  a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("late rvalid");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while busy");
  a_ot_hold: assert property ($rose(overtorque_warn || fault_overtorque)
    |-> hi_cnt_r >= TICK_CYCLES_P) else $error("overtorque too early");
  a_trip_shut: assert property ($rose(fault_overtorque || fault_overheat)
    |-> ##[0:1] output_shutoff) else $error("fault without shut-off");
  a_warn_runs: assert property (overtorque_warn |->
    !output_shutoff || fault_overheat) else $error("warning shut output");
  a_fault_clear: assert property ($fell(fault_overheat) |->
    $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)) else $error("fault lost");
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_warn: cover property (overtorque_warn);
  c_trip: cover property (fault_overtorque && output_shutoff);
endmodule // dcmon_checker
`default_nettype wire

/* tb/drive_condition_monitor_tb_top.sv */
// Bench of the condition monitor with its partner model.
// Assumes a ten-cycle tick stands for a tenth of a second.
`timescale 1ns/100ps
`default_nettype none
module drive_condition_monitor_tb_top;
  import dcmon_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, run_cmd = 1'b0, agree_cmd = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic timer_in_pin = 1'b0, resistor_overheat_input = 1'b0;
  logic [8:0] cur_set = 9'h000;
  logic [11:0] freq_set = 12'h000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire s_axi_rvalid, stall_reduce, contact_out1, contact_out2;
  wire overtorque_warn, output_shutoff, fault_overtorque;
  wire fault_overheat, drive_running, drive_accel, speed_agree;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [8:0] out_current_pct;
  wire [11:0] out_freq;
  wire [2:0] ot_view = {overtorque_warn, fault_overtorque, output_shutoff};
  int fails = 0, checked = 0, cyc = 0;
  dcmon_top #(.TICK_CYCLES_P(10)) dcmon_top_inst (.*);
  dcmon_partner dcmon_partner_inst (.*);
  // Clock at 125 MHz.
  always #4 clk_sys = ~clk_sys;
  // A hang counts as a mismatch.
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check("bresp", s_axi_bresp, a > ADDR_CLEAR ? RESP_SLVERR : RESP_OKAY);
  endtask
  task automatic rc(logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check("rdata", s_axi_rdata, e);
    check("rresp", s_axi_rresp, a > ADDR_CLEAR ? RESP_SLVERR : RESP_OKAY);
  endtask
  task automatic tk(int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Expected frequency contact for detect function fn at offset k.
  function automatic logic fexp(int fn, int k);
    return fn == 3 ? k == 0 : fn == 4 ? k <= 0 : k >= 0;
  endfunction
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence: defaults, clamps, stall, detect, overtorque, timer.
  initial begin
    int a, r, l;
    a = $urandom(20);
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    tk(2);
    rc(ADDR_STALL, {16'h0, RST_RUN_LVL, RST_ACCEL_LVL});
    rc(ADDR_OVT, {8'h0, RST_OT_TIME, RST_OT_LVL, 5'h0, RST_OT_MODE});
    rc(ADDR_PROT, 32'h0);
    rc(8'h20, 32'h0);
    wr(8'h24, 32'hFFFFFFFF);
    wr(ADDR_STALL, 32'h0000FA0A);
    rc(ADDR_STALL, {16'h0, PCT_MAX, PCT_MIN});
    wr(ADDR_OVT, 32'h00C8FF07);
    rc(ADDR_OVT, {8'h0, OT_TIME_MAX, PCT_MAX, 5'h0, OT_MODE_MAX});
    a = 30 + $urandom % 171;
    r = 30 + $urandom % 171;
    wr(ADDR_STALL, 32'(r * 256 + a));
    run_cmd <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      agree_cmd <= i[1];
      cur_set <= 9'((i[1] ? r : a) - 1 + i[0]);
      tk(4);
      check("stall", stall_reduce, i[0]);
    end
    cur_set <= 9'h000;
    l = 1 + $urandom % 3998;
    wr(ADDR_FDET, 32'(l));
    for (int fn = 3; fn < 6; fn++) begin
      wr(ADDR_FUNC, 32'(fn * 257));
      for (int k = -1; k < 2; k++) begin
        freq_set <= 12'(l + k);
        tk(5);
        check("out1", contact_out1, fexp(fn, k));
        check("out2", contact_out2, fexp(fn, k));
      end
    end
    wr(ADDR_FUNC, 32'h00000600);
    for (int m = 0; m < 5; m++) begin
      wr(ADDR_OVT, 32'h00026400 | m);
      agree_cmd <= 1'b0;
      cur_set <= 9'h096;
      tk(12);
      check("ot early", ot_view, 0);
      tk(18);
      check("ot run", ot_view, {m == 2, m == 4, m == 4});
      agree_cmd <= 1'b1;
      tk(30);
      check("ot agree", ot_view,
        {m == 1 || m == 2, m > 2, m > 2});
      if (m < 3) check("ot out2", contact_out2, m > 0);
      cur_set <= 9'h000;
      wr(ADDR_CLEAR, 32'h1);
    end
    wr(ADDR_TIMER, 32'h00000203);
    wr(ADDR_FUNC, 32'h0000000B);
    timer_in_pin <= 1'b1;
    tk(45);
    check("timer fn", contact_out1, 0);
    wr(ADDR_FUNC, 32'h0014000B);
    tk(20);
    timer_in_pin <= 1'b0;
    tk(5);
    timer_in_pin <= 1'b1;
    tk(28);
    check("timer restart", contact_out1, 0);
    tk(12);
    check("timer on", contact_out1, 1);
    timer_in_pin <= 1'b0;
    tk(18);
    check("timer hold", contact_out1, 1);
    tk(12);
    check("timer off", contact_out1, 0);
    resistor_overheat_input <= 1'b1;
    tk(6);
    check("rh off", {fault_overheat, output_shutoff}, 0);
    wr(ADDR_PROT, 32'h1);
    tk(4);
    check("rh trip", {fault_overheat, output_shutoff}, 3);
    give_verdict();
  end
endmodule // drive_condition_monitor_tb_top
bind dcmon_top dcmon_checker #(.TICK_CYCLES_P(TICK_CYCLES_P))
  dcmon_checker_inst (.*);
`default_nettype wire
